// *** iosr_defines.svh ***
`ifndef IOSR_DEFINES_SVH
`define IOSR_DEFINES_SVH
`define IOSR_BIT_LAST 8'h1F
`define IOSR_PORT_LAST 8'h3F
`define IOSR_DATA_OFFSET 8'h20
`define IOSR_DATA_IO_LAST 8'h5F
`define IOSR_EXT_FIRST 8'h60
`define IOSR_LOW_COUNT 32
`define IOSR_FLAG_IO 5'h15
`define IOSR_RESET_VALUE 8'h00
`define IOSR_T2_CTRL_A 8'hB0
`define IOSR_T2_CTRL_B 8'hB1
`define IOSR_T2_COUNT 8'hB2
`define IOSR_T2_CMP_A 8'hB3
`define IOSR_T2_CMP_B 8'hB4
`define IOSR_ASYNC_STATUS 8'hB6
`define IOSR_TW_BIT_RATE 8'hB8
`define IOSR_TW_STATUS 8'hB9
`define IOSR_TW_OWN_ADDR 8'hBA
`define IOSR_TW_DATA 8'hBB
`define IOSR_T2_CTRL_A_MASK 8'hF3
`define IOSR_T2_CTRL_B_MASK 8'h0F
`define IOSR_T2_FORCE_A_BIT 7
`define IOSR_T2_FORCE_B_BIT 6
`define IOSR_ASYNC_RW_MASK 8'h60
`define IOSR_TW_PRESCALE_MASK 8'h03
`endif

// *** iosr_pkg.sv ***
package iosr_pkg;
   typedef enum logic [3:0] {
      IOSR_OP_NONE = 4'h0,
      IOSR_OP_IO_READ = 4'h1,
      IOSR_OP_IO_WRITE = 4'h2,
      IOSR_OP_BIT_SET = 4'h3,
      IOSR_OP_BIT_CLEAR = 4'h4,
      IOSR_OP_SKIP_IF_BIT_SET = 4'h5,
      IOSR_OP_SKIP_IF_BIT_CLEAR = 4'h6,
      IOSR_OP_DATA_READ = 4'h7,
      IOSR_OP_DATA_WRITE = 4'h8
   } iosr_op_e;

   typedef struct packed {
      iosr_op_e op;
      logic [7:0] addr;
      logic [2:0] bit_idx;
      logic [7:0] wdata;
   } iosr_req_s;

   typedef struct packed {
      logic [7:0] ctrl_a;
      logic [7:0] ctrl_b;
      logic [7:0] count;
      logic [7:0] cmp_a;
      logic [7:0] cmp_b;
      logic [7:0] async_ctrl;
   } iosr_timer2_s;

   typedef struct packed {
      logic [7:0] bit_rate;
      logic [7:0] prescale;
      logic [7:0] own_addr;
      logic [7:0] data;
   } iosr_twi_s;

   typedef logic [7:0] iosr_byte_t;
endpackage

// *** iosr_bank.sv ***
`timescale 1ns/10ps
`include "iosr_defines.svh"

module iosr_bank
   import iosr_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   input wire logic i_req_valid,
   input wire iosr_req_s i_req,
   input wire logic [7:0] i_flag_event,
   input wire logic [4:0] i_async_busy,
   input wire logic [4:0] i_twi_state,
   output logic o_ack_q,
   output logic o_err_q,
   output logic [7:0] o_rdata_q,
   output logic o_skip_q,
   output logic [1:0] o_force_q,
   output logic [`IOSR_LOW_COUNT*8-1:0] o_io_regs,
   output iosr_timer2_s o_timer2,
   output iosr_twi_s o_twi
);

   iosr_byte_t low_q [`IOSR_LOW_COUNT];
   iosr_byte_t low_d [`IOSR_LOW_COUNT];
   iosr_timer2_s t2_q;
   iosr_timer2_s t2_d;
   iosr_twi_s tw_q;
   iosr_twi_s tw_d;
   logic ack_d;
   logic err_d;
   logic [7:0] rdata_d;
   logic skip_d;
   logic [1:0] force_d;

   logic ok;
   logic hit_low;
   logic hit_ext;
   logic [5:0] io_addr;
   logic do_write;
   logic is_read;
   logic [7:0] rd_val;
   logic [7:0] wval;
   logic [7:0] bit_mask;
   logic bit_val;

   // Decodes the request into the low bank, the extended bank, an accepted access that hits no register, or a refusal.
   always_comb
   begin
      ok = 1'b0;
      hit_low = 1'b0;
      hit_ext = 1'b0;
      io_addr = 6'h00;
      do_write = 1'b0;
      is_read = 1'b0;
      case (i_req.op)
         IOSR_OP_IO_READ, IOSR_OP_IO_WRITE:
         begin
            ok = (i_req.addr <= `IOSR_PORT_LAST);
            io_addr = i_req.addr[5:0];
            hit_low = ok && (i_req.addr <= `IOSR_BIT_LAST);
            do_write = ok && (i_req.op == IOSR_OP_IO_WRITE);
            is_read = ok && (i_req.op == IOSR_OP_IO_READ);
         end
         IOSR_OP_BIT_SET, IOSR_OP_BIT_CLEAR, IOSR_OP_SKIP_IF_BIT_SET, IOSR_OP_SKIP_IF_BIT_CLEAR:
         begin
            ok = (i_req.addr <= `IOSR_BIT_LAST);
            io_addr = i_req.addr[5:0];
            hit_low = ok;
            do_write = ok && ((i_req.op == IOSR_OP_BIT_SET) || (i_req.op == IOSR_OP_BIT_CLEAR));
         end
         IOSR_OP_DATA_READ, IOSR_OP_DATA_WRITE:
         begin
            ok = (i_req.addr >= `IOSR_DATA_OFFSET);
            if ((i_req.addr >= `IOSR_DATA_OFFSET) && (i_req.addr <= `IOSR_DATA_IO_LAST))
            begin
               io_addr = 6'(i_req.addr - `IOSR_DATA_OFFSET);
               hit_low = (io_addr <= 6'(`IOSR_BIT_LAST));
            end
            hit_ext = (i_req.addr >= `IOSR_EXT_FIRST);
            do_write = ok && (i_req.op == IOSR_OP_DATA_WRITE);
            is_read = ok && (i_req.op == IOSR_OP_DATA_READ);
         end
         default:
         begin
            ok = 1'b0;
         end
      endcase
   end

   // Reads the addressed register; anything unmapped or reserved reads zero.
   always_comb
   begin
      rd_val = 8'h00;
      if (hit_low)
      begin
         rd_val = low_q[io_addr[4:0]];
      end
      else if (hit_ext)
      begin
         case (i_req.addr)
            `IOSR_T2_CTRL_A: rd_val = t2_q.ctrl_a;
            `IOSR_T2_CTRL_B: rd_val = t2_q.ctrl_b;
            `IOSR_T2_COUNT: rd_val = t2_q.count;
            `IOSR_T2_CMP_A: rd_val = t2_q.cmp_a;
            `IOSR_T2_CMP_B: rd_val = t2_q.cmp_b;
            `IOSR_ASYNC_STATUS: rd_val = t2_q.async_ctrl | {3'h0, i_async_busy};
            `IOSR_TW_BIT_RATE: rd_val = tw_q.bit_rate;
            `IOSR_TW_STATUS: rd_val = {i_twi_state, 1'b0, tw_q.prescale[1:0]};
            `IOSR_TW_OWN_ADDR: rd_val = tw_q.own_addr;
            `IOSR_TW_DATA: rd_val = tw_q.data;
            default: rd_val = 8'h00;
         endcase
      end
   end

   // Builds the written value; bit operations rewrite the whole byte.
   always_comb
   begin
      bit_mask = 8'(8'h01 << i_req.bit_idx);
      bit_val = |(rd_val & bit_mask);
      case (i_req.op)
         IOSR_OP_BIT_SET: wval = rd_val | bit_mask;
         IOSR_OP_BIT_CLEAR: wval = rd_val & ~bit_mask;
         default: wval = i_req.wdata;
      endcase
   end

   genvar gi;
   generate
      for (gi = 0; gi < `IOSR_LOW_COUNT; gi++)
      begin : g_low
         logic hit;
         always_comb
         begin
            hit = i_req_valid && do_write && hit_low && (io_addr[4:0] == 5'(gi));
            if (gi == `IOSR_FLAG_IO)
            begin
               // Events win over a clear arriving in the same cycle.
               low_d[gi] = (low_q[gi] & ~(hit ? wval : 8'h00)) | i_flag_event;
            end
            else
            begin
               low_d[gi] = hit ? wval : low_q[gi];
            end
         end
         always_ff @(posedge i_core_clk or negedge i_reset_n)
         begin
            if (!i_reset_n)
            begin
               low_q[gi] <= `IOSR_RESET_VALUE;
            end
            else
            begin
               low_q[gi] <= low_d[gi];
            end
         end
         assign o_io_regs[gi*8 +: 8] = low_q[gi];
      end
   endgenerate

   // Extended registers, with reserved and read-only bits masked off on write.
   always_comb
   begin
      t2_d = t2_q;
      tw_d = tw_q;
      force_d = 2'b00;
      if (i_req_valid && do_write && hit_ext)
      begin
         case (i_req.addr)
            `IOSR_T2_CTRL_A: t2_d.ctrl_a = wval & `IOSR_T2_CTRL_A_MASK;
            `IOSR_T2_CTRL_B:
            begin
               t2_d.ctrl_b = wval & `IOSR_T2_CTRL_B_MASK;
               force_d = {wval[`IOSR_T2_FORCE_A_BIT], wval[`IOSR_T2_FORCE_B_BIT]};
            end
            `IOSR_T2_COUNT: t2_d.count = wval;
            `IOSR_T2_CMP_A: t2_d.cmp_a = wval;
            `IOSR_T2_CMP_B: t2_d.cmp_b = wval;
            `IOSR_ASYNC_STATUS: t2_d.async_ctrl = wval & `IOSR_ASYNC_RW_MASK;
            `IOSR_TW_BIT_RATE: tw_d.bit_rate = wval;
            `IOSR_TW_STATUS: tw_d.prescale = wval & `IOSR_TW_PRESCALE_MASK;
            `IOSR_TW_OWN_ADDR: tw_d.own_addr = wval;
            `IOSR_TW_DATA: tw_d.data = wval;
            default: t2_d = t2_q;
         endcase
      end
   end

   // Answer of each request, one cycle after it is taken.
   always_comb
   begin
      ack_d = i_req_valid;
      err_d = i_req_valid && !ok;
      rdata_d = 8'h00;
      skip_d = 1'b0;
      if (i_req_valid && ok)
      begin
         if (is_read)
         begin
            rdata_d = rd_val;
         end
         if (i_req.op == IOSR_OP_SKIP_IF_BIT_SET)
         begin
            skip_d = bit_val;
         end
         if (i_req.op == IOSR_OP_SKIP_IF_BIT_CLEAR)
         begin
            skip_d = !bit_val;
         end
      end
   end

   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         t2_q <= '0;
         tw_q <= '0;
         o_ack_q <= 1'b0;
         o_err_q <= 1'b0;
         o_rdata_q <= 8'h00;
         o_skip_q <= 1'b0;
         o_force_q <= 2'b00;
      end
      else
      begin
         t2_q <= t2_d;
         tw_q <= tw_d;
         o_ack_q <= ack_d;
         o_err_q <= err_d;
         o_rdata_q <= rdata_d;
         o_skip_q <= skip_d;
         o_force_q <= force_d;
      end
   end

   assign o_timer2 = t2_q;
   assign o_twi = tw_q;

   logic [7:0] chk_flag;
   logic [7:0] chk_target;
   logic chk_is_flag;
   assign chk_flag = low_q[`IOSR_FLAG_IO];
   assign chk_target = low_q[i_req.addr[4:0]];
   assign chk_is_flag = (i_req.addr[4:0] == `IOSR_FLAG_IO);

   AST_BIT_SET: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (i_req_valid && i_req.op == IOSR_OP_BIT_SET && i_req.addr <= 8'h1F && !chk_is_flag)
      |=> (low_q[$past(i_req.addr[4:0])] == ($past(chk_target) | 8'(8'h01 << $past(i_req.bit_idx)))))
      else $error("Bit set did not set the chosen bit.");

   AST_BIT_CLEAR: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (i_req_valid && i_req.op == IOSR_OP_BIT_CLEAR && i_req.addr <= 8'h1F && !chk_is_flag)
      |=> (low_q[$past(i_req.addr[4:0])] == ($past(chk_target) & ~8'(8'h01 << $past(i_req.bit_idx)))))
      else $error("Bit clear did not clear the chosen bit.");

   AST_SKIP_TEST: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (i_req_valid && i_req.op == IOSR_OP_SKIP_IF_BIT_SET && i_req.addr <= 8'h1F)
      |=> (o_skip_q == $past(chk_target[i_req.bit_idx])) && !o_err_q)
      else $error("Skip result does not match the tested bit.");

   AST_W1C_ONE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (i_req_valid && i_req.op == IOSR_OP_IO_WRITE && i_req.addr == 8'h15)
      |=> ((chk_flag & $past(i_req.wdata) & ~$past(i_flag_event)) == 8'h00))
      else $error("Writing one did not clear a flag.");

   AST_W1C_ZERO: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (i_req_valid && i_req.op == IOSR_OP_IO_WRITE && i_req.addr == 8'h15 && i_req.wdata == 8'h00)
      |=> (chk_flag == ($past(chk_flag) | $past(i_flag_event))))
      else $error("Writing zero changed a flag.");

   AST_RMW_CLEARS: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (i_req_valid && i_req.op == IOSR_OP_BIT_SET && i_req.addr == 8'h15)
      |=> (chk_flag == $past(i_flag_event)))
      else $error("Bit set on flag register did not clear set flags.");

   AST_BIT_RANGE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (i_req_valid && (i_req.op == IOSR_OP_BIT_SET || i_req.op == IOSR_OP_BIT_CLEAR) && i_req.addr > 8'h1F)
      |=> o_err_q && $stable(t2_q) && $stable(tw_q))
      else $error("Bit operation outside the low range was not refused.");

   AST_PORT_RANGE: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (i_req_valid && i_req.op == IOSR_OP_IO_WRITE && i_req.addr > 8'h3F)
      |=> o_err_q && $stable(t2_q) && $stable(tw_q))
      else $error("Port write beyond 0x3F was not refused.");

   AST_DATA_OFFSET: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (i_req_valid && i_req.op == IOSR_OP_DATA_READ && i_req.addr >= 8'h20 && i_req.addr <= 8'h3F)
      |=> (o_rdata_q == $past(chk_target)) && o_ack_q)
      else $error("Data-space read did not honour the 0x20 offset.");

   AST_EXT_DATA: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (i_req_valid && i_req.op == IOSR_OP_DATA_WRITE && i_req.addr == 8'hB8)
      |=> (tw_q.bit_rate == $past(i_req.wdata)) ##1 (tw_q.bit_rate == $past(tw_q.bit_rate) || $past(i_req_valid)))
      else $error("Extended register not written by data-space store.");

   AST_RESERVED_READ: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
      (i_req_valid && i_req.op == IOSR_OP_DATA_READ && (i_req.addr == 8'hB5 || i_req.addr == 8'hB7))
      |=> (o_rdata_q == 8'h00))
      else $error("Reserved address did not read zero.");

endmodule

// *** iosr_core_model.sv ***
`timescale 1ns/10ps
module iosr_core_model
   import iosr_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_ack_q,
   input wire logic i_err_q,
   input wire logic [7:0] i_rdata_q,
   input wire logic i_skip_q,
   output logic o_req_valid,
   output iosr_req_s o_req
);
   initial
   begin
      o_req_valid = 1'b0;
      o_req = '0;
   end

   // Issues one request and takes the answer in the cycle after acceptance.
   task automatic issue(input iosr_op_e op, input logic [7:0] addr, input logic [2:0] bi, input logic [7:0] wd,
                        output logic ak, output logic er, output logic [7:0] rd, output logic sk);
      @(negedge i_core_clk);
      o_req_valid = 1'b1;
      o_req = '{op: op, addr: addr, bit_idx: bi, wdata: wd};
      @(negedge i_core_clk);
      o_req_valid = 1'b0;
      o_req = ~o_req;
      ak = i_ack_q;
      er = i_err_q;
      rd = i_rdata_q;
      sk = i_skip_q;
   endtask
endmodule

// *** io_space_register_access_tb_top.sv ***
`timescale 1ns/10ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
   $display("unexpected %s expected %h seen %h", nm, e, g); end end
module io_space_register_access_tb_top
   import iosr_pkg::*;
;
   logic clk, rst_n, req_valid, ack, err, skip, ak, er, sk;
   iosr_req_s req;
   logic [7:0] flag_ev, rdata, rd;
   logic [4:0] busy, twst;
   logic [1:0] frc;
   logic [255:0] io_regs;
   iosr_timer2_s t2;
   iosr_twi_s tw;
   int err_count, checks_done, cycles;
   logic [7:0] da [12] = '{8'hB8, 8'hB0, 8'hB1, 8'hB6, 8'hB9, 8'hB7, 8'h50, 8'hB3, 8'hB2, 8'hB4, 8'hBA, 8'hBB};
   logic [7:0] dx [12] = '{8'hFF, 8'hF3, 8'h0F, 8'h75, 8'h53, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};

   iosr_bank dut (.i_core_clk(clk), .i_reset_n(rst_n), .i_req_valid(req_valid), .i_req(req),
      .i_flag_event(flag_ev), .i_async_busy(busy), .i_twi_state(twst), .o_ack_q(ack), .o_err_q(err),
      .o_rdata_q(rdata), .o_skip_q(skip), .o_force_q(frc), .o_io_regs(io_regs), .o_timer2(t2), .o_twi(tw));
   iosr_core_model core (.i_core_clk(clk), .i_ack_q(ack), .i_err_q(err), .i_rdata_q(rdata), .i_skip_q(skip),
      .o_req_valid(req_valid), .o_req(req));

   always #10 clk = ~clk;

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         wrap_up();
      end
   end

   // Runs one access and checks the acknowledge and the refusal flag.
   task automatic acc(input iosr_op_e op, input logic [7:0] a, input logic [2:0] b, input logic [7:0] w,
                      input logic e);
      core.issue(op, a, b, w, ak, er, rd, sk);
      `CHK("ack", 1'b1, ak)
      `CHK("refusal", e, er)
   endtask

   task automatic t_port_data;
      acc(IOSR_OP_IO_WRITE, 8'h05, 3'h0, 8'hA5, 1'b0);
      `CHK("write rdata", 8'h00, rd)
      `CHK("port write reg", 8'hA5, io_regs[40 +: 8])
      acc(IOSR_OP_IO_READ, 8'h05, 3'h0, 8'h00, 1'b0);
      `CHK("port read", 8'hA5, rd)
      acc(IOSR_OP_DATA_READ, 8'h25, 3'h0, 8'h00, 1'b0);
      `CHK("data alias read", 8'hA5, rd)
      acc(IOSR_OP_DATA_WRITE, 8'h3E, 3'h0, 8'h3C, 1'b0);
      `CHK("alias write reg", 8'h3C, io_regs[240 +: 8])
      acc(IOSR_OP_IO_READ, 8'h1E, 3'h0, 8'h00, 1'b0);
      `CHK("alias write", 8'h3C, rd)
      acc(IOSR_OP_IO_READ, 8'h3F, 3'h0, 8'h00, 1'b0);
      `CHK("reserved port", 8'h00, rd)
      acc(IOSR_OP_IO_WRITE, 8'h40, 3'h0, 8'h11, 1'b1);
      acc(IOSR_OP_DATA_READ, 8'h1F, 3'h0, 8'h00, 1'b1);
      acc(IOSR_OP_NONE, 8'h05, 3'h0, 8'h00, 1'b1);
   endtask

   task automatic t_bits;
      acc(IOSR_OP_IO_WRITE, 8'h1F, 3'h0, 8'h40, 1'b0);
      acc(IOSR_OP_BIT_SET, 8'h1F, 3'h3, 8'h00, 1'b0);
      acc(IOSR_OP_BIT_CLEAR, 8'h1F, 3'h6, 8'h00, 1'b0);
      acc(IOSR_OP_IO_READ, 8'h1F, 3'h0, 8'h00, 1'b0);
      `CHK("bit ops", 8'h08, rd)
      `CHK("bit ops reg", 8'h08, io_regs[248 +: 8])
      acc(IOSR_OP_SKIP_IF_BIT_SET, 8'h1F, 3'h3, 8'h00, 1'b0);
      `CHK("skip set", 1'b1, sk)
      acc(IOSR_OP_SKIP_IF_BIT_CLEAR, 8'h1F, 3'h3, 8'h00, 1'b0);
      `CHK("skip clear hi", 1'b0, sk)
      acc(IOSR_OP_SKIP_IF_BIT_CLEAR, 8'h1F, 3'h0, 8'h00, 1'b0);
      `CHK("skip clear lo", 1'b1, sk)
      acc(IOSR_OP_BIT_SET, 8'h20, 3'h0, 8'h00, 1'b1);
      acc(IOSR_OP_BIT_CLEAR, 8'h25, 3'h0, 8'h00, 1'b1);
      acc(IOSR_OP_IO_READ, 8'h05, 3'h0, 8'h00, 1'b0);
      `CHK("refused bit op", 8'hA5, rd)
   endtask

   task automatic t_flags;
      @(negedge clk);
      flag_ev = 8'h81;
      @(negedge clk);
      flag_ev = 8'h00;
      acc(IOSR_OP_IO_READ, 8'h15, 3'h0, 8'h00, 1'b0);
      `CHK("flags", 8'h81, rd)
      acc(IOSR_OP_IO_WRITE, 8'h15, 3'h0, 8'h01, 1'b0);
      acc(IOSR_OP_IO_WRITE, 8'h15, 3'h0, 8'h00, 1'b0);
      acc(IOSR_OP_IO_READ, 8'h15, 3'h0, 8'h00, 1'b0);
      `CHK("flag clear", 8'h80, rd)
      flag_ev = 8'h01;
      acc(IOSR_OP_IO_WRITE, 8'h15, 3'h0, 8'h01, 1'b0);
      flag_ev = 8'h00;
      acc(IOSR_OP_IO_READ, 8'h15, 3'h0, 8'h00, 1'b0);
      `CHK("set beats clear", 8'h81, rd)
      acc(IOSR_OP_SKIP_IF_BIT_SET, 8'h15, 3'h7, 8'h00, 1'b0);
      `CHK("flag skip", 1'b1, sk)
      acc(IOSR_OP_BIT_SET, 8'h15, 3'h0, 8'h00, 1'b0);
      acc(IOSR_OP_DATA_READ, 8'h35, 3'h0, 8'h00, 1'b0);
      `CHK("rmw clears", 8'h00, rd)
   endtask

   task automatic t_ext;
      for (int i = 0; i < 12; i++)
      begin
         acc(IOSR_OP_DATA_WRITE, da[i], 3'h0, 8'hFF, 1'b0);
         acc(IOSR_OP_DATA_READ, da[i], 3'h0, 8'h00, 1'b0);
         `CHK("extended read", dx[i], rd)
      end
      `CHK("timer2 regs", 48'hF30FFFFFFF60, t2)
      `CHK("two wire regs", 32'hFF03FFFF, tw)
      acc(IOSR_OP_DATA_WRITE, 8'hB1, 3'h0, 8'hC0, 1'b0);
      `CHK("force strobes", 2'b11, frc)
      acc(IOSR_OP_DATA_READ, 8'hB1, 3'h0, 8'h00, 1'b0);
      `CHK("force read back", 8'h00, rd)
      `CHK("force pulse end", 2'b00, frc)
      acc(IOSR_OP_IO_READ, 8'hB8, 3'h0, 8'h00, 1'b1);
      acc(IOSR_OP_IO_READ, 8'h40, 3'h0, 8'h00, 1'b1);
   endtask

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      rst_n = 1'b0;
      flag_ev = 8'h00;
      busy = 5'h15;
      twst = 5'h0A;
      err_count = 0;
      checks_done = 0;
      cycles = 0;
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      t_port_data();
      t_bits();
      t_flags();
      t_ext();
      wrap_up();
   end
endmodule
